// ### logic/sssq_pkg.sv
// Shared constants, states and carriers of the soft-start fault sequencer
package sssq_pkg;

	// Core clock and switching rate; all sequencing counts in switching cycles
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned FSW_HZ = 500_000;
	localparam int unsigned SW_DIV = CLK_HZ / FSW_HZ;
	localparam int unsigned DIV_W = $clog2(SW_DIV);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SW_DIV - 1);

	// Phase count
	localparam int unsigned NPH = 3;

	// Reference code: one LSB per switching cycle of ramp, 1280 LSB per volt
	localparam int unsigned REF_W = 12;
	localparam int unsigned RAMP_PER_VOLT = 1280;

	// Start delay and hiccup wait, in switching cycles
	localparam int unsigned START_DELAY_CYC = 64;
	localparam int unsigned HICCUP_CYC = 4096;
	localparam int unsigned CNT_W = 13;
	localparam logic [CNT_W-1:0] DELAY_LAST = CNT_W'(START_DELAY_CYC - 1);
	localparam logic [CNT_W-1:0] HICCUP_LAST = CNT_W'(HICCUP_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;

	// Remote-sense offset: 100 mV in reference LSBs, gone after 640 cycles
	localparam int unsigned OFS_MV = 100;
	localparam int unsigned OFS_RAMP_CYC = 640;
	localparam int unsigned OFS_W = 8;
	localparam logic [OFS_W-1:0] OFS_START =
		OFS_W'(OFS_MV * RAMP_PER_VOLT / 1000);
	localparam int unsigned OFS_STEP_CYC = OFS_RAMP_CYC / (OFS_MV *
		RAMP_PER_VOLT / 1000);
	localparam logic [2:0] OFS_STEP_LAST = 3'(OFS_STEP_CYC - 1);
	localparam logic [OFS_W-1:0] OFS_ZERO = '0;
	localparam logic [REF_W-1:0] REF_ZERO = '0;
	localparam logic [REF_W-1:0] REF_ONE = 12'h001;

	// Sequencer states
	typedef enum logic [2:0] {
		SSSQ_OFF = 3'b000,
		SSSQ_DELAY = 3'b001,
		SSSQ_RAMP = 3'b010,
		SSSQ_RUN = 3'b011,
		SSSQ_HICCUP = 3'b100,
		SSSQ_OPEN = 3'b101
	} sssq_state_e;

	// Per-phase output drive modes
	typedef enum logic [1:0] {
		SSSQ_DRV_HIZ = 2'b00,
		SSSQ_DRV_OFF = 2'b01,
		SSSQ_DRV_PWM = 2'b10,
		SSSQ_DRV_CLAMP = 2'b11
	} sssq_drv_e;

	// Analog comparator results, all active high
	typedef struct packed {
		logic enable_level_in;   // Enable above its threshold
		logic bias_ok;           // Core and driver_supply above POR
		logic fb_above_ramp;     // feedback_node above ramping reference
		logic precharge_high;    // Output above final reference
		logic uv_trip;           // Output below 82 % of setpoint
		logic uv_clear;          // Output above 85 % of setpoint
		logic ov_fixed_trip;     // Above fixed trip level
		logic ov_fixed_clear;    // 100 mV below fixed trip level
		logic ov_track_trip;     // Above setpoint plus 150 mV
		logic ov_track_clear;    // 100 mV below tracking trip level
		logic open_sense;        // local_output_sense over diff_amp_output+1V
		logic oc_trip;           // droop_voltage over overcurrent_setpoint
	} sssq_cmp_s;

	// Sequencer status bundle
	typedef struct packed {
		sssq_state_e state;
		logic ss_done;
		logic uv_active;
		logic ov_active;
		logic pin_mismatch;
	} sssq_status_s;

endpackage

// ### logic/sssq_sequencer.sv
// Soft-start, power-good and fault sequencer for a three-phase buck
`timescale 1ns/10ps
`default_nettype none

module sssq_sequencer
	import sssq_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire sssq_cmp_s cmp_in,
	input wire logic [REF_W-1:0] ref_target_in,
	input wire logic [NPH-1:0] pwm_in,
	input wire logic supply_ok_in,
	output logic [REF_W-1:0] ref_ramp_out,
	output logic [OFS_W-1:0] sense_offset_out,
	output logic [NPH-1:0] upper_gate_drive,
	output logic [NPH-1:0] lower_gate_drive,
	output logic [NPH-1:0] phase_hiz_out,
	output logic supply_ok_out,
	output logic supply_ok_oe_n,
	output logic overvoltage_flag_out,
	output sssq_status_s status_out
);

	sssq_cmp_s meta_q;
	sssq_cmp_s cmp_q;
	logic [DIV_W-1:0] div_q;
	logic tick_q;
	sssq_state_e state_q;
	sssq_state_e state_d;
	logic [CNT_W-1:0] cnt_q;
	logic [REF_W-1:0] ramp_q;
	logic [OFS_W-1:0] ofs_q;
	logic [2:0] ofs_div_q;
	logic released_q;
	logic post_ss_q;
	logic uv_q;
	logic ov_q;
	logic run_en;
	logic ramp_done;
	logic ov_trip;
	logic ov_clear;
	sssq_drv_e drv_mode;
	logic pg_good;

	// Two-flop synchroniser; first stage feeds nothing but the second
	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_q <= '0;
			cmp_q <= '0;
		end else begin
			meta_q <= cmp_in;
			cmp_q <= meta_q;
		end
	end

	// Switching-cycle tick derived from the core clock
	always_ff @(posedge core_clk) begin
		if (rst) begin
			div_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (div_q == DIV_LAST);
			if (div_q == DIV_LAST) begin
				div_q <= '0;
			end else begin
				div_q <= div_q + 1'b1;
			end
		end
	end

	// Enable and both bias supplies together release shutdown
	assign run_en = cmp_q.enable_level_in & cmp_q.bias_ok;
	assign ramp_done = (ramp_q >= ref_target_in);

	// Sequencer next state; disable beats every fault, open sense beats OC
	always_comb begin
		state_d = state_q;
		if (!run_en) begin
			state_d = SSSQ_OFF;
		end else if (cmp_q.open_sense && state_q != SSSQ_OFF) begin
			state_d = SSSQ_OPEN;
		end else if (cmp_q.oc_trip && (state_q == SSSQ_RAMP ||
			state_q == SSSQ_RUN)) begin
			state_d = SSSQ_HICCUP;
		end else begin
			case (state_q)
			SSSQ_OFF: begin
				state_d = SSSQ_DELAY;
			end
			SSSQ_DELAY: begin
				if (tick_q && cnt_q == DELAY_LAST) begin
					state_d = SSSQ_RAMP;
				end
			end
			SSSQ_RAMP: begin
				if (ramp_done) begin
					state_d = SSSQ_RUN;
				end
			end
			SSSQ_RUN: begin
				state_d = SSSQ_RUN;
			end
			SSSQ_HICCUP: begin
				if (tick_q && cnt_q == HICCUP_LAST) begin
					state_d = SSSQ_DELAY;
				end
			end
			SSSQ_OPEN: begin
				state_d = SSSQ_DELAY;
			end
			default: begin
				state_d = SSSQ_OFF;
			end
			endcase
		end
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= SSSQ_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// Delay and hiccup counter, cleared on every state change
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (state_d != state_q) begin
			cnt_q <= CNT_ZERO;
		end else if (tick_q) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// Reference ramp: one LSB per switching cycle, 1280 LSB per volt
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ramp_q <= '0;
		end else if (state_q == SSSQ_RAMP) begin
			if (ramp_done) begin
				ramp_q <= ref_target_in;
			end else if (tick_q) begin
				ramp_q <= ramp_q + REF_ONE;
			end
		end else if (state_q == SSSQ_RUN) begin
			ramp_q <= ref_target_in; // Target may move once running
		end else begin
			ramp_q <= REF_ZERO;
		end
	end

	// Sense offset: full at start, one LSB off every five switching cycles in ramp and run
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ofs_q <= '0;
			ofs_div_q <= '0;
		end else if (state_q == SSSQ_RAMP || state_q == SSSQ_RUN) begin
			if (tick_q && ofs_q != OFS_ZERO) begin
				if (ofs_div_q == OFS_STEP_LAST) begin
					ofs_div_q <= '0;
					ofs_q <= ofs_q - 1'b1;
				end else begin
					ofs_div_q <= ofs_div_q + 1'b1;
				end
			end
		end else begin
			ofs_q <= OFS_START;
			ofs_div_q <= '0;
		end
	end

	// Drive release during ramp; a precharged output waits for the end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			released_q <= 1'b0;
		end else if (state_q == SSSQ_RUN) begin
			released_q <= 1'b1;
		end else if (state_q == SSSQ_RAMP) begin
			if (!cmp_q.fb_above_ramp && !cmp_q.precharge_high) begin
				released_q <= 1'b1;
			end
		end else begin
			released_q <= 1'b0;
		end
	end

	// Post-start flag picks the tracking overvoltage level
	always_ff @(posedge core_clk) begin
		if (rst) begin
			post_ss_q <= 1'b0;
		end else if (state_q == SSSQ_RAMP && state_d == SSSQ_RUN) begin
			post_ss_q <= 1'b1;
		end else if (state_q != SSSQ_RUN) begin
			post_ss_q <= 1'b0;
		end
	end

	// Active overvoltage trip and release levels
	assign ov_trip = post_ss_q ? cmp_q.ov_track_trip :
		cmp_q.ov_fixed_trip;
	assign ov_clear = post_ss_q ? cmp_q.ov_track_clear :
		cmp_q.ov_fixed_clear;

	// Overvoltage latch; a fresh trip wins over a clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ov_q <= 1'b0;
		end else if (state_q == SSSQ_OFF) begin
			ov_q <= 1'b0;
		end else if (ov_trip) begin
			ov_q <= 1'b1;
		end else if (ov_clear) begin
			ov_q <= 1'b0;
		end
	end

	// Undervoltage latch with 82/85 % hysteresis; only gates supply-ok
	always_ff @(posedge core_clk) begin
		if (rst) begin
			uv_q <= 1'b0;
		end else if (state_q != SSSQ_RUN) begin
			uv_q <= 1'b0;
		end else if (cmp_q.uv_trip) begin
			uv_q <= 1'b1;
		end else if (cmp_q.uv_clear) begin
			uv_q <= 1'b0;
		end
	end

	// Drive mode; open sense and hiccup turn both switches off
	always_comb begin
		drv_mode = SSSQ_DRV_HIZ;
		case (state_q)
		SSSQ_OFF: begin
			drv_mode = SSSQ_DRV_HIZ;
		end
		SSSQ_OPEN, SSSQ_HICCUP: begin
			drv_mode = SSSQ_DRV_OFF;
		end
		SSSQ_DELAY, SSSQ_RAMP, SSSQ_RUN: begin
			if (ov_q) begin
				drv_mode = SSSQ_DRV_CLAMP;
			end else if (released_q) begin
				drv_mode = SSSQ_DRV_PWM;
			end else begin
				drv_mode = SSSQ_DRV_HIZ;
			end
		end
		default: begin
			drv_mode = SSSQ_DRV_HIZ;
		end
		endcase
	end

	// Per-phase gate registers
	for (genvar p = 0; p < NPH; p++) begin : g_phase
		always_ff @(posedge core_clk) begin
			if (rst) begin
				upper_gate_drive[p] <= 1'b0;
				lower_gate_drive[p] <= 1'b0;
				phase_hiz_out[p] <= 1'b1;
			end else begin
				case (drv_mode)
				SSSQ_DRV_PWM: begin
					upper_gate_drive[p] <= pwm_in[p];
					lower_gate_drive[p] <= ~pwm_in[p];
					phase_hiz_out[p] <= 1'b0;
				end
				SSSQ_DRV_CLAMP: begin
					upper_gate_drive[p] <= 1'b0;
					lower_gate_drive[p] <= 1'b1;
					phase_hiz_out[p] <= 1'b0;
				end
				SSSQ_DRV_OFF: begin
					upper_gate_drive[p] <= 1'b0;
					lower_gate_drive[p] <= 1'b0;
					phase_hiz_out[p] <= 1'b0;
				end
				default: begin
					upper_gate_drive[p] <= 1'b0;
					lower_gate_drive[p] <= 1'b0;
					phase_hiz_out[p] <= 1'b1;
				end
				endcase
			end
		end
	end

	// Supply-ok good only after start with no fault; OC leaves RUN at once
	assign pg_good = (state_q == SSSQ_RUN) && post_ss_q && !uv_q && !ov_q &&
		!cmp_q.oc_trip;

	// Open-drain supply-ok: enable low means the pin is pulled low
	always_ff @(posedge core_clk) begin
		if (rst) begin
			supply_ok_out <= 1'b0;
			supply_ok_oe_n <= 1'b0;
		end else begin
			supply_ok_out <= 1'b0;
			supply_ok_oe_n <= pg_good;
		end
	end

	// Crowbar flag follows the overvoltage latch
	always_ff @(posedge core_clk) begin
		if (rst) begin
			overvoltage_flag_out <= 1'b0;
		end else begin
			overvoltage_flag_out <= ov_q;
		end
	end

	// Reference, offset and status outputs, all registered
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ref_ramp_out <= '0;
			sense_offset_out <= '0;
			status_out <= '0;
		end else begin
			ref_ramp_out <= ramp_q;
			sense_offset_out <= ofs_q;
			status_out.state <= state_q;
			status_out.ss_done <= post_ss_q;
			status_out.uv_active <= uv_q;
			status_out.ov_active <= ov_q;
			// Released but held low: another party shares the wire
			status_out.pin_mismatch <= supply_ok_oe_n & ~supply_ok_in;
		end
	end

endmodule

`default_nettype wire

// ### testbench/sssq_far_model.sv
// Far-side model: enable comparator, supply-ok pull-up, modulator
`timescale 1ns/10ps
`default_nettype none
module sssq_far_model
	import sssq_pkg::*;
(
	input wire logic core_clk,
	input var int en_mv,
	input wire logic ok_oe_n,
	input wire logic ok_out,
	output logic en_ok,
	output logic ok_wire,
	output logic [NPH-1:0] pwm
);
	// Hysteresis keeps a noisy enable from bouncing the sequencer
	initial en_ok = 1'b0;
	always @(posedge core_clk) begin
		if (en_mv > 660)
			en_ok <= 1'b1;
		else if (en_mv < 560)
			en_ok <= 1'b0;
	end
	// Open-drain wire, pull-up when released
	assign ok_wire = ok_oe_n ? 1'b1 : ok_out;
	// Pattern changes every cycle
	initial pwm = 3'h5;
	always @(posedge core_clk) pwm <= ~pwm;
endmodule
`default_nettype wire

// ### testbench/sssq_sequencer_sva.sv
// Port checker for the sequencer
`timescale 1ns/10ps
`default_nettype none
module sssq_sequencer_sva
	import sssq_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire sssq_cmp_s cmp_in,
	input wire logic [REF_W-1:0] ref_target_in,
	input wire logic [NPH-1:0] pwm_in,
	input wire logic supply_ok_in,
	input wire logic [REF_W-1:0] ref_ramp_out,
	input wire logic [OFS_W-1:0] sense_offset_out,
	input wire logic [NPH-1:0] upper_gate_drive,
	input wire logic [NPH-1:0] lower_gate_drive,
	input wire logic [NPH-1:0] phase_hiz_out,
	input wire logic supply_ok_out,
	input wire logic supply_ok_oe_n,
	input wire logic overvoltage_flag_out,
	input wire sssq_status_s status_out
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sssq_state_e st;
	logic g_off, ovl, seen_q;
	logic [REF_W-1:0] last_q;
	int dly_q, gap_q;
	assign st = status_out.state;
	assign ovl = status_out.ov_active;
	assign g_off = upper_gate_drive == '0 && lower_gate_drive == '0;
	// Cycles in delay; ramp spacing, first step skipped as phase is free
	always_ff @(posedge core_clk) begin
		dly_q <= (st == SSSQ_DELAY) ? dly_q + 1 : 0;
	end
	always_ff @(posedge core_clk) begin
		last_q <= ref_ramp_out;
		gap_q <= (st != SSSQ_RAMP || ref_ramp_out != last_q) ? 0 : gap_q + 1;
		seen_q <= st == SSSQ_RAMP && (seen_q || ref_ramp_out != last_q);
	end
	a_off_hiz: assert property (
		st == SSSQ_OFF |-> phase_hiz_out == 3'h7 && g_off && !supply_ok_oe_n)
		else $error("outputs not parked in shutdown");
	a_ok_needs_run: assert property (
		supply_ok_oe_n |-> st == SSSQ_RUN && status_out.ss_done
		&& !status_out.uv_active && !ovl)
		else $error("supply ok released early");
	a_delay_quiet: assert property (
		st == SSSQ_DELAY && !ovl |-> g_off && phase_hiz_out == 3'h7)
		else $error("drives active in delay");
	a_delay_len: assert property (
		st == SSSQ_RAMP && $past(st) == SSSQ_DELAY
		|-> dly_q >= 12601 && dly_q <= 12801)
		else $error("start delay length wrong");
	a_ramp_step: assert property (
		st == SSSQ_RAMP && seen_q && ref_ramp_out != last_q
		|-> gap_q == 199 && ref_ramp_out == last_q + REF_ONE)
		else $error("ramp step wrong");
	a_ov_clamp: assert property (
		ovl && st inside {SSSQ_DELAY, SSSQ_RAMP, SSSQ_RUN}
		|-> lower_gate_drive == 3'h7 && upper_gate_drive == '0)
		else $error("lower gates not clamped");
	a_flag_ov: assert property (
		overvoltage_flag_out == ovl && (!ovl || !supply_ok_oe_n))
		else $error("flag does not follow overvoltage");
	a_fault_off: assert property (
		st inside {SSSQ_OPEN, SSSQ_HICCUP} |-> g_off && !supply_ok_oe_n)
		else $error("drives on during fault");
	a_hold_off: assert property (
		(cmp_in.precharge_high || cmp_in.fb_above_ramp) [*6]
		##0 (st == SSSQ_RAMP && !ovl) |-> g_off)
		else $error("drives on while output above ramp");
	a_uv_only: assert property (
		status_out.uv_active && !ovl && st == SSSQ_RUN
		|-> phase_hiz_out == '0 && !supply_ok_oe_n)
		else $error("undervoltage response wrong");
	c_run: cover property (st == SSSQ_RUN && supply_ok_oe_n);
	c_ov: cover property (ovl);
	c_open: cover property (st == SSSQ_OPEN);
	c_hic: cover property (st == SSSQ_HICCUP);
endmodule
bind sssq_sequencer sssq_sequencer_sva i_sssq_sequencer_sva (.core_clk,
	.rst, .cmp_in, .ref_target_in, .pwm_in, .supply_ok_in, .ref_ramp_out,
	.sense_offset_out, .upper_gate_drive, .lower_gate_drive, .phase_hiz_out,
	.supply_ok_out, .supply_ok_oe_n, .overvoltage_flag_out, .status_out);
`default_nettype wire

// ### testbench/sssq_sequencer_tb.sv
// Self-checking bench for the sequencer
`timescale 1ns/10ps
`default_nettype none
module sssq_sequencer_tb
	import sssq_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	sssq_cmp_s c = 12'h654;
	sssq_cmp_s cmp_w;
	logic [REF_W-1:0] tgt = 12'h020;
	logic [REF_W-1:0] ramp;
	logic [OFS_W-1:0] ofs;
	logic [NPH-1:0] pwm, ug, lg, hiz;
	logic en_ok, ok_wire, ok_out, ok_oe_n, ovf;
	sssq_status_s sts;
	// Another party pulling the shared supply-ok wire low
	logic ext_low = 1'b0;
	int en_mv = 0;
	int errors = 0;
	int checks_done = 0;
	int n, cnt, t0;
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) cnt++;
	// Enable bit comes through the hysteresis model
	always_comb begin
		cmp_w = c;
		cmp_w.enable_level_in = en_ok;
	end
	sssq_sequencer i_sssq_sequencer (.core_clk(core_clk), .rst(rst),
		.cmp_in(cmp_w), .ref_target_in(tgt), .pwm_in(pwm),
		.supply_ok_in(ok_wire & ~ext_low), .ref_ramp_out(ramp),
		.sense_offset_out(ofs),
		.upper_gate_drive(ug), .lower_gate_drive(lg), .phase_hiz_out(hiz),
		.supply_ok_out(ok_out), .supply_ok_oe_n(ok_oe_n),
		.overvoltage_flag_out(ovf), .status_out(sts));
	sssq_far_model i_sssq_far_model (.core_clk(core_clk), .en_mv(en_mv),
		.ok_oe_n(ok_oe_n), .ok_out(ok_out), .en_ok(en_ok),
		.ok_wire(ok_wire), .pwm(pwm));
	task automatic close_out();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// Whole cycles, then settle past the edge
	task automatic cyc(int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	// Bounded wait for a state; a miss ends the run
	task automatic wst(sssq_state_e s, int lim);
		n = 0;
		while (sts.state !== s && n < lim) begin
			cyc(1);
			n++;
		end
		if (sts.state !== s) begin
			chk("state", 16'(sts.state), 16'(s));
			close_out();
		end
	endtask
	// Trip b with clear b-1; the other pair o must be ignored
	task automatic ovt(int b, int o);
		@(posedge core_clk) c[o] <= 1'b1;
		cyc(8);
		chk("other pair", 16'(ovf), 16'h0);
		@(posedge core_clk) c[o] <= 1'b0;
		c[b] <= 1'b1;
		c[b-1] <= 1'b0;
		cyc(8);
		chk("ov flag", 16'(ovf), 16'h1);
		chk("clamp", 16'(lg), 16'h7);
		chk("ok wire", 16'(ok_wire), 16'h0);
		@(posedge core_clk) c[b] <= 1'b0;
		cyc(8);
		chk("ov hold", 16'(ovf), 16'h1);
		@(posedge core_clk) c[b-1] <= 1'b1;
		cyc(8);
		chk("ov clear", 16'(ovf), 16'h0);
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		cyc(2);
		chk("hiz", 16'(hiz), 16'h7);
		chk("ok wire", 16'(ok_wire), 16'h0);
		$display("test reset done");
		@(posedge core_clk) en_mv <= 700;
		wst(SSSQ_DELAY, 8);
		t0 = cnt;
		chk("hiz", 16'(hiz), 16'h7);
		ovt(5, 3);
		wst(SSSQ_RAMP, 13000);
		n = cnt - t0;
		chk("delay", 16'(n >= 12600 && n <= 12802), 16'h1);
		chk("offset", 16'(ofs), 16'(OFS_START));
		t0 = cnt;
		cyc(600);
		chk("gates", 16'({ug, lg}), 16'h0);
		@(posedge core_clk) c.fb_above_ramp <= 1'b0;
		cyc(8);
		chk("released", 16'(hiz), 16'h0);
		chk("pwm pass", 16'({ug, lg}), 16'({~pwm, pwm}));
		wst(SSSQ_RUN, 7000);
		n = cnt - t0;
		chk("ramp time", 16'(n >= 6200 && n <= 6800), 16'h1);
		chk("ramp", 16'(ramp), 16'(tgt));
		chk("offset down", 16'(ofs < OFS_START), 16'h1);
		cyc(2);
		chk("ok wire", 16'(ok_wire), 16'h1);
		chk("done", 16'(sts.ss_done), 16'h1);
		@(posedge core_clk) ext_low <= 1'b1;
		cyc(4);
		chk("mismatch", 16'(sts.pin_mismatch), 16'h1);
		@(posedge core_clk) ext_low <= 1'b0;
		cyc(4);
		chk("no mismatch", 16'(sts.pin_mismatch), 16'h0);
		$display("test start done");
		@(posedge core_clk) c.uv_trip <= 1'b1;
		c.uv_clear <= 1'b0;
		cyc(8);
		chk("uv ok", 16'(ok_wire), 16'h0);
		chk("uv run", 16'({sts.state, hiz}), 16'h18);
		@(posedge core_clk) c.uv_trip <= 1'b0;
		cyc(8);
		chk("uv band", 16'(ok_wire), 16'h0);
		@(posedge core_clk) c.uv_clear <= 1'b1;
		cyc(8);
		chk("uv back", 16'(ok_wire), 16'h1);
		ovt(3, 5);
		ovt(3, 5);
		chk("ov back", 16'(ok_wire), 16'h1);
		$display("test faults done");
		@(posedge core_clk) c.open_sense <= 1'b1;
		cyc(8);
		chk("open", 16'({sts.state, ug, lg}), 16'h140);
		@(posedge core_clk) c.precharge_high <= 1'b1;
		c.open_sense <= 1'b0;
		wst(SSSQ_DELAY, 8);
		wst(SSSQ_RAMP, 13000);
		cyc(600);
		chk("precharged", 16'({ug, lg}), 16'h0);
		wst(SSSQ_RUN, 7000);
		cyc(2);
		chk("end start", 16'(hiz), 16'h0);
		@(posedge core_clk) c.precharge_high <= 1'b0;
		c.oc_trip <= 1'b1;
		cyc(8);
		chk("oc", 16'({sts.state, ug, lg}), 16'h100);
		chk("oc ok", 16'(ok_wire), 16'h0);
		@(posedge core_clk) c.oc_trip <= 1'b0;
		en_mv <= 600;
		cyc(8);
		chk("hyst", 16'(sts.state), 16'(SSSQ_HICCUP));
		@(posedge core_clk) en_mv <= 500;
		cyc(8);
		chk("off", 16'({sts.state, hiz}), 16'h7);
		$display("test shutdown done");
		close_out();
	end
endmodule
`default_nettype wire
